// file: rtl/ldp_pkg.sv
// Shared constants, types and decode functions for the LED pulse/breathe PWM block
package ldp_pkg;
	// Register offsets
	localparam logic [7:0] OFF_SP_PER  = 8'h84;
	localparam logic [7:0] OFF_RP_PER  = 8'h85;
	localparam logic [7:0] OFF_BREATH_PERIOD_FIELD  = 8'h86;
	localparam logic [7:0] OFF_CFG     = 8'h88;
	localparam logic [7:0] OFF_SP_DUTY = 8'h90;
	localparam logic [7:0] OFF_RP_DUTY = 8'h91;
	localparam logic [7:0] OFF_BR_DUTY = 8'h92;
	localparam logic [7:0] OFF_DR_DUTY = 8'h93;
	// Values after reset
	localparam logic [7:0] RST_SP_PER  = 8'h20;
	localparam logic [7:0] RST_RP_PER  = 8'h14;
	localparam logic [7:0] RST_BREATH_PERIOD_FIELD  = 8'h5D;
	localparam logic [7:0] RST_CFG     = 8'h04;
	localparam logic [7:0] RST_DUTY    = 8'hF0;
	// Field positions
	localparam int TRIG_BIT    = 7;
	localparam int ALERT_BIT   = 6;
	localparam int REP_CNT_LSB = 3;
	localparam int SGL_CNT_LSB = 0;
	localparam int MAX_LSB     = 4;
	// Timing: one period unit, its cycle count and ramp resolution
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_MS       = 32;
	localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SUBSTEPS      = 64;
	localparam logic [12:0] HALF_UNIT = 13'h0020;
	localparam logic [6:0]  PWM_STEPS = 7'h64;
	// Behaviour codes
	typedef enum logic [1:0] {
		BEH_DIRECT  = 2'b00,
		BEH_SINGLE  = 2'b01,
		BEH_REPEAT  = 2'b10,
		BEH_BREATHE = 2'b11
	} ldp_beh_e;
	// Channel sequencer states
	typedef enum logic [2:0] {
		CH_IDLE = 3'b001,
		CH_UP   = 3'b010,
		CH_DOWN = 3'b100
	} ldp_ch_e;
	// Maximum-duty code to percent
	function automatic logic [6:0] duty_pct(input logic [3:0] c);
		logic [6:0] p;
		p = 7'h64;
		case (c)
			4'h0: p = 7'h07;
			4'h1: p = 7'h09;
			4'h2: p = 7'h0B;
			4'h3: p = 7'h0E;
			4'h4: p = 7'h11;
			4'h5: p = 7'h14;
			4'h6: p = 7'h17;
			4'h7: p = 7'h1A;
			4'h8: p = 7'h1E;
			4'h9: p = 7'h23;
			4'hA: p = 7'h28;
			4'hB: p = 7'h2E;
			4'hC: p = 7'h35;
			4'hD: p = 7'h3F;
			4'hE: p = 7'h4D;
			default: p = 7'h64;
		endcase
		return p;
	endfunction
	// Minimum code n is maximum code n-1, zero gives 0 percent
	function automatic logic [6:0] min_pct(input logic [3:0] c);
		return (c == 4'h0) ? 7'h00 : duty_pct(c - 4'h1);
	endfunction
	// Ramp half length in substeps; a zero field counts as one
	function automatic logic [12:0] half_len(input logic [6:0] per);
		return (per == 7'h00) ? HALF_UNIT : {1'b0, per, 5'h00};
	endfunction
endpackage

// file: rtl/ldp_channel.sv
// One LED channel: trigger detect, breath sequencer and duty level
`timescale 1ns/1ps
module ldp_channel (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        clk_en_i,
	input  wire logic        sub_i,
	input  wire logic [1:0]  mode_i,
	input  wire logic        act_i,
	input  wire logic        start_rel_i,
	input  wire logic        src_ctl_i,
	input  wire logic [6:0]  lo_i,
	input  wire logic [6:0]  hi_i,
	input  wire logic [12:0] half_i,
	input  wire logic [2:0]  cnt_i,
	output logic [6:0]       duty_o,
	output logic             busy_o,
	output logic             done_o,
	output logic             from_ctl_o
);
	ldp_pkg::ldp_ch_e state;
	logic        act_q;
	logic [1:0]  mode_q;
	logic        src_q;
	logic        stop_q;
	logic [2:0]  rem;
	logic [6:0]  lo_q;
	logic [6:0]  hi_q;
	logic [6:0]  lvl;
	logic [12:0] half_q;
	logic [12:0] scnt;
	logic [15:0] acc;

	// Edges and start decode
	wire rise     = act_i & ~act_q;
	wire fall     = ~act_i & act_q;
	wire start_ev = (mode_i == ldp_pkg::BEH_SINGLE) ? (start_rel_i ? fall : rise) : rise;
	wire go       = (state == ldp_pkg::CH_IDLE) && (mode_i != ldp_pkg::BEH_DIRECT) && start_ev;
	// Step the level by one whenever the accumulator passes the half length
	wire [6:0]  diff   = (hi_q > lo_q) ? (hi_q - lo_q) : 7'h00;
	wire [15:0] acc_n  = acc + {9'h000, diff};
	wire        step   = acc_n >= {3'h0, half_q};
	wire        at_hi  = lvl >= hi_q;
	wire        at_lo  = lvl <= lo_q;
	wire        up_end = sub_i && (state == ldp_pkg::CH_UP) && (scnt >= half_q) && at_hi;
	wire        dn_end = sub_i && (state == ldp_pkg::CH_DOWN) && (scnt >= half_q) && at_lo;
	wire        counted = (mode_q == ldp_pkg::BEH_SINGLE) || ((mode_q == ldp_pkg::BEH_REPEAT) && stop_q);
	wire        finish = dn_end && counted && (rem == 3'h0);
	wire        kill   = (state != ldp_pkg::CH_IDLE) && (mode_q == ldp_pkg::BEH_BREATHE) && fall;

	// Sequencer; settings are latched at start so later writes wait for re-actuation
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state  <= ldp_pkg::CH_IDLE;
			act_q  <= 1'b0;
			mode_q <= ldp_pkg::BEH_DIRECT;
			src_q  <= 1'b0;
			stop_q <= 1'b0;
			rem    <= 3'h0;
			lo_q   <= 7'h00;
			hi_q   <= 7'h00;
			half_q <= ldp_pkg::HALF_UNIT;
			done_o <= 1'b0;
		end else if (clk_en_i) begin
			act_q  <= act_i;
			done_o <= finish;
			case (state)
				ldp_pkg::CH_IDLE: if (go) begin
					state  <= ldp_pkg::CH_UP;
					mode_q <= mode_i;
					src_q  <= src_ctl_i;
					stop_q <= 1'b0;
					rem    <= cnt_i;
					lo_q   <= lo_i;
					hi_q   <= hi_i;
					half_q <= half_i;
				end
				ldp_pkg::CH_UP: if (kill) state <= ldp_pkg::CH_IDLE;
				else if (up_end) state <= ldp_pkg::CH_DOWN;
				ldp_pkg::CH_DOWN: if (kill || finish) state <= ldp_pkg::CH_IDLE;
				else if (dn_end) begin
					state <= ldp_pkg::CH_UP;
					if (counted) rem <= rem - 3'h1;
				end
				default: state <= ldp_pkg::CH_IDLE;
			endcase
			// Repeat pulse finishes its counted breaths after release
			if (state != ldp_pkg::CH_IDLE && mode_q == ldp_pkg::BEH_REPEAT && fall && !stop_q) begin
				stop_q <= 1'b1;
				rem    <= cnt_i;
			end
		end
	end

	// Ramp level; one step per substep at most, so short periods stretch
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			lvl  <= 7'h00;
			acc  <= 16'h0000;
			scnt <= 13'h0000;
		end else if (clk_en_i) begin
			if (go || up_end || dn_end) begin
				acc  <= 16'h0000;
				scnt <= 13'h0000;
				if (go) lvl <= lo_i;
			end else if (sub_i && state != ldp_pkg::CH_IDLE) begin
				if (scnt < half_q) scnt <= scnt + 13'h0001;
				if ((state == ldp_pkg::CH_UP) ? !at_hi : !at_lo) begin
					acc <= step ? (acc_n - {3'h0, half_q}) : acc_n;
					if (step) lvl <= (state == ldp_pkg::CH_UP) ? lvl + 7'h01 : lvl - 7'h01;
				end
			end
		end
	end

	// Direct follows live settings at once; idle sits at minimum
	assign duty_o = (state != ldp_pkg::CH_IDLE) ? lvl :
		((mode_i == ldp_pkg::BEH_DIRECT && act_i) ? hi_i : lo_i);
	assign busy_o     = state != ldp_pkg::CH_IDLE;
	assign from_ctl_o = src_q;
endmodule

// file: rtl/ldp_led_pwm.sv
// Three-channel LED pulse/breathe PWM with period, count and duty registers
`timescale 1ns/1ps
// How it works
// - Period fields count in 32 ms units; value N means N times 32 ms.
// - Periods span 32 ms to 4.064 s; zero behaves like one.
// - Single-shot period sets each pulse period; resets to 20h, 1024 ms.
// - Trigger bit 7 clear starts a single shot on touch or set; set starts it on release or clear.
// - Repeat-pulse period field resets to 14h, 640 ms.
// - Breathe period field resets to 5Dh, 2976 ms.
// - Too-short periods run at the shortest period the duty limits allow.
// - Alert bit 6 set asserts low alert when a control-driven behaviour finishes.
// - Touch-started activity never raises the finished alert.
// - Count code n gives n+1 breaths; bits 5-3 repeat, bits 2-0 single.
// - Config resets to 04h: five single breaths, one repeat, alert off.
// - Duty registers 90h-93h hold max code high nibble, min low nibble.
// - A breath ramps minimum to maximum then back to minimum.
// - Max codes 0-15 select 7 up to 100 percent.
// - Min code 0 is 0 percent; code n equals max code n-1.
// - Direct duty changes apply at once; other modes need re-actuation.
// - Behaviour code: 00 direct, 01 single, 10 repeat, 11 breathe.
// - Up and down ramps each take half of the breath period.
module ldp_led_pwm #(
	parameter int TICK_CYCLES = ldp_pkg::TICK_CYCLES
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       clk_en_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic [7:0]      reg_rdata_o,
	input  wire logic [2:0] touch_i,
	input  wire logic [2:0] led_link_i,
	input  wire logic [2:0] led_out_ctl_i,
	input  wire logic [5:0] led_behaviour_sel_i,
	input  wire logic [2:0] led_polarity_sel_i,
	input  wire logic       alert_clr_i,
	output logic [2:0]      led_o,
	output logic            alert_n_o
);
	localparam int SUB_CYCLES = TICK_CYCLES / ldp_pkg::SUBSTEPS;

	////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] single_pulse_period;
	logic [7:0] repeat_pulse_period;
	logic [7:0] breathe_period;
	logic [7:0] led_behaviour_config;
	logic [7:0] single_pulse_duty;
	logic [7:0] repeat_pulse_duty;
	logic [7:0] breathe_duty;
	logic [7:0] direct_duty;
	logic [7:0] rd_mux;

	// Write strobes per register
	wire wr_sp  = reg_wr_i && (reg_addr_i == ldp_pkg::OFF_SP_PER);
	wire wr_rp  = reg_wr_i && (reg_addr_i == ldp_pkg::OFF_RP_PER);
	wire wr_br  = reg_wr_i && (reg_addr_i == ldp_pkg::OFF_BREATH_PERIOD_FIELD);
	wire wr_cfg = reg_wr_i && (reg_addr_i == ldp_pkg::OFF_CFG);
	wire wr_spd = reg_wr_i && (reg_addr_i == ldp_pkg::OFF_SP_DUTY);
	wire wr_rpd = reg_wr_i && (reg_addr_i == ldp_pkg::OFF_RP_DUTY);
	wire wr_brd = reg_wr_i && (reg_addr_i == ldp_pkg::OFF_BR_DUTY);
	wire wr_drd = reg_wr_i && (reg_addr_i == ldp_pkg::OFF_DR_DUTY);

	// Period and config registers; unused top bits are kept at zero so they read back zero
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			single_pulse_period <= ldp_pkg::RST_SP_PER;
			repeat_pulse_period <= ldp_pkg::RST_RP_PER;
			breathe_period      <= ldp_pkg::RST_BREATH_PERIOD_FIELD;
			led_behaviour_config <= ldp_pkg::RST_CFG;
		end else if (clk_en_i) begin
			if (wr_sp) single_pulse_period <= reg_wdata_i;
			if (wr_rp) repeat_pulse_period <= {1'b0, reg_wdata_i[6:0]};
			if (wr_br) breathe_period <= {1'b0, reg_wdata_i[6:0]};
			if (wr_cfg) led_behaviour_config <= {1'b0, reg_wdata_i[6:0]};
		end
	end

	// Duty registers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			single_pulse_duty <= ldp_pkg::RST_DUTY;
			repeat_pulse_duty <= ldp_pkg::RST_DUTY;
			breathe_duty      <= ldp_pkg::RST_DUTY;
			direct_duty       <= ldp_pkg::RST_DUTY;
		end else if (clk_en_i) begin
			if (wr_spd) single_pulse_duty <= reg_wdata_i;
			if (wr_rpd) repeat_pulse_duty <= reg_wdata_i;
			if (wr_brd) breathe_duty <= reg_wdata_i;
			if (wr_drd) direct_duty <= reg_wdata_i;
		end
	end

	// Read selection; unmapped offsets read zero
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr_i)
			ldp_pkg::OFF_SP_PER:  rd_mux = single_pulse_period;
			ldp_pkg::OFF_RP_PER:  rd_mux = repeat_pulse_period;
			ldp_pkg::OFF_BREATH_PERIOD_FIELD:  rd_mux = breathe_period;
			ldp_pkg::OFF_CFG:     rd_mux = led_behaviour_config;
			ldp_pkg::OFF_SP_DUTY: rd_mux = single_pulse_duty;
			ldp_pkg::OFF_RP_DUTY: rd_mux = repeat_pulse_duty;
			ldp_pkg::OFF_BR_DUTY: rd_mux = breathe_duty;
			ldp_pkg::OFF_DR_DUTY: rd_mux = direct_duty;
			default:              rd_mux = 8'h00;
		endcase
	end

	// Read data is held until the next read
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) reg_rdata_o <= 8'h00;
		else if (clk_en_i && reg_rd_i) reg_rdata_o <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////////
	// Field decode

	wire       start_on_release_sel = single_pulse_period[ldp_pkg::TRIG_BIT];
	wire [6:0] single_period_field  = single_pulse_period[6:0];
	wire [6:0] repeat_period_field  = repeat_pulse_period[6:0];
	wire [6:0] breath_period_field  = breathe_period[6:0];
	wire       alert_en             = led_behaviour_config[ldp_pkg::ALERT_BIT];
	wire [2:0] repeat_breath_count  = led_behaviour_config[ldp_pkg::REP_CNT_LSB +: 3];
	wire [2:0] single_breath_count  = led_behaviour_config[ldp_pkg::SGL_CNT_LSB +: 3];

	// Ramp half lengths in substeps: 32 substeps per period unit
	wire [12:0] sp_half = ldp_pkg::half_len(single_period_field);
	wire [12:0] rp_half = ldp_pkg::half_len(repeat_period_field);
	wire [12:0] br_half = ldp_pkg::half_len(breath_period_field);

	// Duty codes to percent per behaviour
	wire [6:0] sp_hi = ldp_pkg::duty_pct(single_pulse_duty[ldp_pkg::MAX_LSB +: 4]);
	wire [6:0] sp_lo = ldp_pkg::min_pct(single_pulse_duty[3:0]);
	wire [6:0] rp_hi = ldp_pkg::duty_pct(repeat_pulse_duty[ldp_pkg::MAX_LSB +: 4]);
	wire [6:0] rp_lo = ldp_pkg::min_pct(repeat_pulse_duty[3:0]);
	wire [6:0] br_hi = ldp_pkg::duty_pct(breathe_duty[ldp_pkg::MAX_LSB +: 4]);
	wire [6:0] br_lo = ldp_pkg::min_pct(breathe_duty[3:0]);
	wire [6:0] dr_hi = ldp_pkg::duty_pct(direct_duty[ldp_pkg::MAX_LSB +: 4]);
	wire [6:0] dr_lo = ldp_pkg::min_pct(direct_duty[3:0]);

	////////////////////////////////////////////////////////////////////////////
	// Time base and PWM frame

	logic [19:0] pre_cnt;
	logic [6:0]  pwm_cnt;
	wire         sub_pulse = clk_en_i && (pre_cnt == 20'h00000);

	// Divider: 64 substeps make one 32 ms period unit
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) pre_cnt <= 20'h00000;
		else if (clk_en_i) pre_cnt <= (pre_cnt == 20'(SUB_CYCLES - 1)) ? 20'h00000 : pre_cnt + 20'h00001;
	end

	// PWM frame of 100 clocks so duty compares directly in percent
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) pwm_cnt <= 7'h00;
		else if (clk_en_i) pwm_cnt <= (pwm_cnt == ldp_pkg::PWM_STEPS - 7'h01) ? 7'h00 : pwm_cnt + 7'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// Channels

	logic [6:0] duty_w [3];
	logic [2:0] act_w;
	logic [2:0] busy_w;
	logic [2:0] done_w;
	logic [2:0] from_ctl_w;
	logic       alert_q;

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_ch
			wire [1:0]  led_behaviour_sel = led_behaviour_sel_i[2*i +: 2];
			wire        is_sgl = led_behaviour_sel == ldp_pkg::BEH_SINGLE;
			wire        is_rep = led_behaviour_sel == ldp_pkg::BEH_REPEAT;
			wire        is_br  = led_behaviour_sel == ldp_pkg::BEH_BREATHE;
			// Settings of the selected behaviour
			wire [6:0]  lo   = is_sgl ? sp_lo : is_rep ? rp_lo : is_br ? br_lo : dr_lo;
			wire [6:0]  hi   = is_sgl ? sp_hi : is_rep ? rp_hi : is_br ? br_hi : dr_hi;
			wire [12:0] half = is_sgl ? sp_half : is_rep ? rp_half : br_half;
			wire [2:0]  cnt  = is_rep ? repeat_breath_count : single_breath_count;
			// Linked LEDs follow touch, others follow their output-control bit
			assign act_w[i] = led_link_i[i] ? touch_i[i] : led_out_ctl_i[i];

			ldp_channel u_ch (
				.clk_sys_i   (clk_sys_i),
				.rst_i       (rst_i),
				.clk_en_i    (clk_en_i),
				.sub_i       (sub_pulse),
				.mode_i      (led_behaviour_sel),
				.act_i       (act_w[i]),
				.start_rel_i (start_on_release_sel),
				.src_ctl_i   (~led_link_i[i]),
				.lo_i        (lo),
				.hi_i        (hi),
				.half_i      (half),
				.cnt_i       (cnt),
				.duty_o      (duty_w[i]),
				.busy_o      (busy_w[i]),
				.done_o      (done_w[i]),
				.from_ctl_o  (from_ctl_w[i])
			);

			// Registered pin; polarity 1 is non-inverted
			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i) led_o[i] <= 1'b0;
				else if (clk_en_i) led_o[i] <= (pwm_cnt < duty_w[i]) ^ ~led_polarity_sel_i[i];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Finished alert

	// Only behaviours started from the control bits may raise it
	wire [2:0] done_ctl  = done_w & from_ctl_w;
	wire       alert_set = alert_en && (|done_ctl);

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) alert_q <= 1'b0;
		else if (clk_en_i) alert_q <= alert_set | (alert_q & ~alert_clr_i);
	end

	assign alert_n_o = ~alert_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	a_sub_spacing: assert property (
		sub_pulse |=> !sub_pulse)
		else $error("substep pulses back to back");

	a_zero_period: assert property (
		(breath_period_field == 7'h00) |-> (br_half == ldp_pkg::HALF_UNIT))
		else $error("zero period differs from one");

	a_period_scale: assert property (
		(single_period_field != 7'h00) |-> (sp_half == 13'(single_period_field) * ldp_pkg::HALF_UNIT))
		else $error("period not scaled by unit");

	a_period_store: assert property (
		(clk_en_i && wr_sp) |=> (single_pulse_period == $past(reg_wdata_i)))
		else $error("single period write lost");

	a_release_start: assert property (
		(clk_en_i && $past(clk_en_i) && !busy_w[0] && start_on_release_sel
			&& g_ch[0].is_sgl && $fell(act_w[0])) |=> busy_w[0])
		else $error("release did not start single pulse");

	a_alert_gated: assert property (
		$fell(alert_n_o) |-> $past(alert_en && (|done_ctl)))
		else $error("alert without enabled finish");

	a_touch_quiet: assert property (
		(clk_en_i && alert_n_o && !(|done_ctl)) |=> alert_n_o)
		else $error("touch activity raised alert");

	a_max_top: assert property (
		(breathe_duty[7:4] == 4'hF) |-> (br_hi == 7'h64))
		else $error("max code 15 not full duty");

	a_min_shift: assert property (
		(breathe_duty[3:0] == 4'hF) |-> (br_lo == 7'h4D))
		else $error("min code 15 not 77 percent");

	a_direct_live: assert property (
		(g_ch[0].led_behaviour_sel == ldp_pkg::BEH_DIRECT && !busy_w[0] && act_w[0])
			|-> (duty_w[0] == dr_hi))
		else $error("direct duty not applied at once");

	a_repeat_store: assert property (
		(clk_en_i && wr_rp) |=> (repeat_pulse_period == {1'b0, $past(reg_wdata_i[6:0])}))
		else $error("repeat period write lost");

	a_breath_store: assert property (
		(clk_en_i && wr_br) |=> (breathe_period == {1'b0, $past(reg_wdata_i[6:0])}))
		else $error("breathe period write lost");

	a_cfg_store: assert property (
		(clk_en_i && wr_cfg) |=> (led_behaviour_config == {1'b0, $past(reg_wdata_i[6:0])}))
		else $error("config write lost");

	a_duty_store: assert property (
		(clk_en_i && wr_brd) |=> (breathe_duty == $past(reg_wdata_i)))
		else $error("duty write lost");

	a_alert_hold: assert property (
		(!alert_n_o && !alert_clr_i) |=> !alert_n_o)
		else $error("alert dropped without clear");

	a_alert_clear: assert property (
		(clk_en_i && !alert_n_o && alert_clr_i && !alert_set) |=> alert_n_o)
		else $error("alert not cleared");

	a_alert_off: assert property (
		(!alert_en && alert_n_o) |=> alert_n_o)
		else $error("alert raised while disabled");

	a_direct_idle: assert property (
		(g_ch[0].led_behaviour_sel == ldp_pkg::BEH_DIRECT && !busy_w[0]) |=> !busy_w[0])
		else $error("direct mode started a sequence");

	a_duty_limit: assert property (
		(duty_w[0] <= 7'h64))
		else $error("duty above full scale");

	a_pwm_frame: assert property (
		(pwm_cnt < ldp_pkg::PWM_STEPS))
		else $error("pwm frame overrun");

	a_tick_range: assert property (
		(pre_cnt < 20'(SUB_CYCLES)))
		else $error("divider overrun");

	a_time_freeze: assert property (
		(!clk_en_i) |=> ($stable(pre_cnt) && $stable(pwm_cnt) && $stable(single_pulse_period)))
		else $error("state moved while clock enable low");

	a_ramp_start: assert property (
		$rose(busy_w[0]) |-> (duty_w[0] == $past(g_ch[0].lo)))
		else $error("breath did not start at minimum");

	a_breathe_stop: assert property (
		(clk_en_i && $past(clk_en_i) && busy_w[0] && $fell(act_w[0])
			&& g_ch[0].u_ch.mode_q == ldp_pkg::BEH_BREATHE) |=> !busy_w[0])
		else $error("breathe did not stop on release");

	c_single_done: cover property (done_w[0] && g_ch[0].is_sgl);
	c_alert_fall:  cover property ($fell(alert_n_o));
	c_repeat_busy: cover property (busy_w[1] && g_ch[1].is_rep);
	c_breathe_busy: cover property (busy_w[0] && g_ch[0].is_br);
	c_release_go:  cover property ($rose(busy_w[0]) && start_on_release_sel);
endmodule

// file: tb/ldp_led_model.sv
// LED load model: measures lit clocks per 100-clock window on each pin
`timescale 1ns/1ps
module ldp_led_model (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [2:0]  led_i,
	input  wire logic [2:0]  pol_i,
	output logic [2:0][6:0]  duty_o
);
	logic [6:0]      frame_cnt;
	logic [2:0][6:0] on_cnt;
	logic [2:0]      lit;

	// Inverted LEDs glow while the pin is low
	assign lit = ~(led_i ^ pol_i);

	// Any 100-clock window gives the percent of a steady PWM
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			frame_cnt <= 7'h00;
			on_cnt    <= '0;
			duty_o    <= '0;
		end else begin
			frame_cnt <= (frame_cnt == 7'h63) ? 7'h00 : frame_cnt + 7'h01;
			for (int i = 0; i < 3; i++) begin
				on_cnt[i] <= (frame_cnt == 7'h63) ? 7'h00 : on_cnt[i] + {6'h00, lit[i]};
				if (frame_cnt == 7'h63) begin
					duty_o[i] <= on_cnt[i] + {6'h00, lit[i]};
				end
			end
		end
	end
endmodule

// file: tb/ldp_led_pwm_tb.sv
// Self-checking bench for the LED pulse/breathe PWM block
`timescale 1ns/1ps
module ldp_led_pwm_tb;
	localparam int TICK = 640;
	localparam int BREATH = 2 * 32 * 16 * (TICK / 64); // Field 10h, up plus down
	localparam logic [6:0] PCT [16] = '{7'h07, 7'h09, 7'h0B, 7'h0E, 7'h11, 7'h14, 7'h17,
		7'h1A, 7'h1E, 7'h23, 7'h28, 7'h2E, 7'h35, 7'h3F, 7'h4D, 7'h64};
	localparam logic [15:0] RSTV [9] = '{16'h8420, 16'h8514, 16'h865D, 16'h8804,
		16'h90F0, 16'h91F0, 16'h92F0, 16'h93F0, 16'h8700};
	localparam logic [23:0] ROWS [9] = '{24'h84A5A5, 24'h85FF7F, 24'h868000, 24'h88FF7F,
		24'h903C3C, 24'h911212, 24'h92F0F0, 24'h930F0F, 24'h875500};

	logic            clk_sys_i = 1'b0;
	logic            rst_i = 1'b1;
	logic [7:0]      reg_addr_i = 8'h00;
	logic [7:0]      reg_wdata_i = 8'h00;
	logic            reg_wr_i = 1'b0;
	logic            reg_rd_i = 1'b0;
	logic [7:0]      reg_rdata_o;
	logic [2:0]      touch_i = 3'h0;
	logic [2:0]      led_link_i = 3'h0;
	logic [2:0]      led_out_ctl_i = 3'h0;
	logic [5:0]      led_behaviour_sel_i = 6'h00;
	logic [2:0]      led_polarity_sel_i = 3'h5;
	logic            alert_clr_i = 1'b0;
	logic            clk_en_i = 1'b1;
	logic [2:0]      led_o;
	logic            alert_n_o;
	logic [2:0][6:0] duty;
	int              n_errors = 0;
	int              compares = 0;
	int              n, t0, t1;

	ldp_led_pwm #(.TICK_CYCLES(TICK)) DUT (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .touch_i(touch_i),
		.led_link_i(led_link_i), .led_out_ctl_i(led_out_ctl_i),
		.led_behaviour_sel_i(led_behaviour_sel_i), .led_polarity_sel_i(led_polarity_sel_i),
		.alert_clr_i(alert_clr_i), .led_o(led_o), .alert_n_o(alert_n_o));

	ldp_led_model LEDS (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .led_i(led_o),
		.pol_i(led_polarity_sel_i), .duty_o(duty));

	// 25 MHz system clock
	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare and bus tasks
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t value got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chk_num(input int got, input int exp);
		compares++;
		if (got != exp) begin
			n_errors++;
			$display("MISMATCH t=%0t breath count got %0d exp %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data is registered at the strobe edge, so look one edge later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk_val(reg_rdata_o, exp);
	endtask

	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		chk_flag(alert_n_o, 1'b1);
		chk_val({5'h00, led_o}, 8'h00);
		rst_i <= 1'b0;
	endtask

	// Counts climbs to 90 percent or more on LED0; stops early when the alert drops
	task automatic run_count(input int lim, output int cnt, output int ta, output int tb);
		bit hi;
		hi = 1'b0;
		cnt = 0;
		ta = 0;
		tb = 0;
		for (int c = 0; c < lim; c++) begin
			@(negedge clk_sys_i);
			if (alert_n_o === 1'b0) break;
			if (!hi && duty[0] >= 7'h5A) begin
				cnt++;
				ta = (cnt == 1) ? c : ta;
				tb = c;
			end
			hi = (duty[0] >= 7'h5A);
		end
		@(posedge clk_sys_i);
	endtask

	task automatic clr_alert();
		@(posedge clk_sys_i);
		alert_clr_i <= 1'b1;
		@(posedge clk_sys_i);
		alert_clr_i <= 1'b0;
		@(negedge clk_sys_i);
		chk_flag(alert_n_o, 1'b1);
		@(posedge clk_sys_i);
	endtask

	task automatic finish_test();
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog sized well above the expected run
	initial begin
		repeat (95000) @(posedge clk_sys_i);
		n_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		finish_test();
	end

	// Main sequence
	initial begin
		do_reset();
		foreach (RSTV[i]) rd(RSTV[i][15:8], RSTV[i][7:0]);
		foreach (ROWS[i]) wr(ROWS[i][23:16], ROWS[i][15:8]);
		foreach (ROWS[i]) rd(ROWS[i][23:16], ROWS[i][7:0]);
		@(posedge clk_sys_i);
		do_reset();
		foreach (RSTV[i]) rd(RSTV[i][15:8], RSTV[i][7:0]);
		// Direct: LED1 inverted, limits rewritten while lit
		@(posedge clk_sys_i);
		led_out_ctl_i <= 3'b011;
		for (int c = 0; c < 16; c++) begin
			wr(8'h93, {c[3:0], c[3:0]});
			repeat (250) @(posedge clk_sys_i);
			chk_val({1'b0, duty[0]}, {1'b0, PCT[c]});
			chk_val({1'b0, duty[1]}, {1'b0, PCT[c]});
			led_out_ctl_i <= 3'b000;
			repeat (250) @(posedge clk_sys_i);
			chk_val({1'b0, duty[0]}, (c == 0) ? 8'h00 : {1'b0, PCT[c - 1]});
			led_out_ctl_i <= 3'b011;
		end
		// Single pulse, two breaths, limits written mid-run must wait
		@(posedge clk_sys_i);
		led_out_ctl_i <= 3'b000;
		wr(8'h84, 8'h01);
		wr(8'h88, 8'h41);
		led_behaviour_sel_i <= 6'b000001;
		@(posedge clk_sys_i);
		led_out_ctl_i <= 3'b001;
		wr(8'h90, 8'h00);
		run_count(8000, n, t0, t1);
		chk_num(n, 2);
		chk_flag(alert_n_o, 1'b0);
		clr_alert();
		// Touch start never raises the alert
		led_out_ctl_i <= 3'b000;
		wr(8'h88, 8'h40);
		wr(8'h90, 8'hF0);
		led_link_i <= 3'b001;
		touch_i <= 3'b001;
		run_count(4000, n, t0, t1);
		chk_num(n, 1);
		chk_flag(alert_n_o, 1'b1);
		// Start on release
		touch_i <= 3'b000;
		led_link_i <= 3'b000;
		wr(8'h84, 8'h81);
		wr(8'h88, 8'h00);
		@(posedge clk_sys_i);
		led_out_ctl_i <= 3'b001;
		run_count(3000, n, t0, t1);
		chk_num(n, 0);
		led_out_ctl_i <= 3'b000;
		run_count(3000, n, t0, t1);
		chk_num(n, 1);
		// Repeat pulse released early: three breaths then alert
		wr(8'h85, 8'h01);
		wr(8'h88, 8'h50);
		led_behaviour_sel_i <= 6'b000010;
		@(posedge clk_sys_i);
		led_out_ctl_i <= 3'b001;
		repeat (20) @(posedge clk_sys_i);
		led_out_ctl_i <= 3'b000;
		run_count(10000, n, t0, t1);
		chk_num(n, 3);
		chk_flag(alert_n_o, 1'b0);
		clr_alert();
		// Breathe period scales with the field
		wr(8'h88, 8'h00);
		wr(8'h86, 8'h10);
		led_behaviour_sel_i <= 6'b000011;
		@(posedge clk_sys_i);
		led_out_ctl_i <= 3'b001;
		run_count(21000, n, t0, t1);
		chk_num(n, 2);
		chk_flag((t1 - t0 > BREATH - 300) && (t1 - t0 < BREATH + 300), 1'b1);
		led_out_ctl_i <= 3'b000;
		repeat (250) @(posedge clk_sys_i);
		chk_val({1'b0, duty[0]}, 8'h00);
		// Clock enable low must drop a register write
		clk_en_i <= 1'b0;
		wr(8'h84, 8'h55);
		clk_en_i <= 1'b1;
		rd(8'h84, 8'h81);
		finish_test();
	end
endmodule
